// ==== usp_consts.svh ====
`ifndef USP_CONSTS_SVH
`define USP_CONSTS_SVH

// Clock
`define USP_CLK_PERIOD_NS 8

// Divisor width and sleep-enable position inside the interrupt enable register
`define USP_DIVISOR_W 16
`define USP_IER_SLEEP_BIT 4

// Modem status change bits 0-3
`define USP_MSR_CHG_W 4

// Line side idle time before the charge pump stops
`define USP_PUMP_IDLE_TIME_S 30
`define USP_PUMP_IDLE_CYCLES (64'd`USP_PUMP_IDLE_TIME_S * 64'd1000000000 / 64'd`USP_CLK_PERIOD_NS)

// Charge pump return to full operation
`define USP_PUMP_RESTART_NS 45000
`define USP_PUMP_RESTART_CYCLES \
  ((`USP_PUMP_RESTART_NS + `USP_CLK_PERIOD_NS - 1) / `USP_CLK_PERIOD_NS)

// Crystal oscillator settling after restart
`define USP_OSC_SETTLE_NS 1000
`define USP_OSC_SETTLE_CYCLES \
  ((`USP_OSC_SETTLE_NS + `USP_CLK_PERIOD_NS - 1) / `USP_CLK_PERIOD_NS)
`define USP_OSC_CNT_W 8

// Reset values
`define USP_BUS_IDLE_RST 14'h3FFF

`endif

// ==== usp_pkg.sv ====
package usp_pkg;

  typedef enum logic [1:0] {
    UART_ACTIVE,
    UART_SLEEP,
    UART_WAKING
  } usp_uart_e;

  typedef enum logic [1:0] {
    PUMP_ON,
    PUMP_OFF,
    PUMP_RESTART
  } usp_pump_e;

  // Host bus inputs as seen by the core
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
    logic chipSelectN;
    logic readStrobeN;
    logic writeStrobeN;
  } usp_bus_s;

  // Line side and strap pins
  typedef struct packed {
    logic rxd;
    logic [3:0] modem;
    logic chargePumpAutosleepPin;
    logic busIsolatePin;
  } usp_line_s;

endpackage : usp_pkg

// ==== usp_power_ctrl.sv ====
`timescale 1ns/100ps
`include "usp_consts.svh"

module usp_power_ctrl #(
  parameter logic [31:0] PUMP_IDLE_CYCLES = 32'(`USP_PUMP_IDLE_CYCLES),
  parameter logic [12:0] PUMP_RESTART_CYCLES = 13'(`USP_PUMP_RESTART_CYCLES)
) (
  input wire logic clk, // 125 MHz crystal clock
  input wire logic rst_b, // Synchronous reset
  input wire usp_pkg::usp_line_s linePins, // Raw rx, modem, strap pins
  input wire usp_pkg::usp_bus_s busPins, // Raw host bus inputs
  input wire logic intPending, // Core has an interrupt pending
  input wire logic [`USP_DIVISOR_W-1:0] baudDivisor, // Divisor high and low bytes
  input wire logic [7:0] interruptEnableReg, // Interrupt enable register image
  input wire logic [`USP_MSR_CHG_W-1:0] msrChange, // Modem status bits 0-3
  input wire logic txActive, // Transmit output busy
  input wire logic thrWrite, // Byte written to transmit holding or FIFO
  input wire logic isrRead, // Interrupt source register read
  output usp_pkg::usp_bus_s coreBus_reg, // Bus inputs passed to the core
  output logic oscRun_reg, // Crystal oscillator enable
  output logic uartAsleep_reg, // UART section asleep
  output logic busIsolated_reg, // Power-save isolation active
  output logic wakeInt_reg, // Wake interrupt pending
  output logic [3:0] isrNibble_reg, // Wake nibble for interrupt source
  output logic pumpEnable_reg, // Charge pump running
  output logic driverEnable_reg, // RS-232 drivers enabled
  output logic fullSleep_reg // Oscillator and pump both stopped
);

  usp_pkg::usp_line_s lineMeta_reg;
  usp_pkg::usp_line_s lineSync_reg;
  usp_pkg::usp_bus_s busMeta_reg;
  usp_pkg::usp_bus_s busSync_reg;
  logic rxdPrev_reg;
  logic [3:0] modemPrev_reg;
  usp_pkg::usp_uart_e uartState_reg;
  usp_pkg::usp_uart_e uartState_next;
  usp_pkg::usp_pump_e pumpState_reg;
  usp_pkg::usp_pump_e pumpState_next;
  logic [`USP_OSC_CNT_W-1:0] oscCnt_reg;
  logic [12:0] pumpCnt_reg;
  logic [31:0] idleCnt_reg;
  logic psWake_reg;
  logic sleepEnable;
  logic otherIntEnabled;
  logic rxRise;
  logic modemRise;
  logic lineIdle;
  logic sleepOk;
  logic uartWake;
  logic oscSettled;
  logic wakeDone;
  logic isolateNow;
  logic pumpEvent;
  logic pumpIdle;
  logic oscRestart;

  // Every pin passes two flops; only the second stage is read
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lineMeta_reg <= '0;
      lineSync_reg <= '0;
      busMeta_reg <= usp_pkg::usp_bus_s'(`USP_BUS_IDLE_RST);
      busSync_reg <= usp_pkg::usp_bus_s'(`USP_BUS_IDLE_RST);
    end
    else
    begin
      lineMeta_reg <= linePins;
      lineSync_reg <= lineMeta_reg;
      busMeta_reg <= busPins;
      busSync_reg <= busMeta_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rxdPrev_reg <= 1'b0;
      modemPrev_reg <= 4'h0;
    end
    else
    begin
      rxdPrev_reg <= lineSync_reg.rxd;
      modemPrev_reg <= lineSync_reg.modem;
    end
  end

  assign sleepEnable = interruptEnableReg[`USP_IER_SLEEP_BIT];
  assign otherIntEnabled = |(interruptEnableReg & ~(8'h01 << `USP_IER_SLEEP_BIT));
  assign rxRise = lineSync_reg.rxd && !rxdPrev_reg;
  assign modemRise = |(lineSync_reg.modem & ~modemPrev_reg);
  assign lineIdle = !txActive && !lineSync_reg.rxd && (lineSync_reg.modem == 4'h0);

  // A pending wake interrupt also blocks sleep, so reading the status is required to re-sleep
  assign sleepOk = !intPending && !wakeInt_reg && (baudDivisor != 16'h0000)
    && sleepEnable && (msrChange == 4'h0) && !lineSync_reg.rxd;

  // Bus writes cannot reach the core while isolated, so only line events and a cleared sleep-enable count then
  assign uartWake = rxRise || (msrChange != 4'h0)
    || (thrWrite && !busIsolated_reg) || !sleepEnable;

  assign oscSettled = (oscCnt_reg == `USP_OSC_CNT_W'(`USP_OSC_SETTLE_CYCLES));
  assign wakeDone = (uartState_reg == usp_pkg::UART_WAKING) && oscSettled;
  assign isolateNow = (uartState_reg == usp_pkg::UART_SLEEP) && lineSync_reg.busIsolatePin;

  always_comb
  begin
    uartState_next = uartState_reg;
    unique case (uartState_reg)
      usp_pkg::UART_ACTIVE:
      begin
        if (sleepOk)
        begin
          uartState_next = usp_pkg::UART_SLEEP;
        end
      end
      usp_pkg::UART_SLEEP:
      begin
        if (uartWake)
        begin
          uartState_next = usp_pkg::UART_WAKING;
        end
      end
      usp_pkg::UART_WAKING:
      begin
        if (oscSettled)
        begin
          uartState_next = usp_pkg::UART_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      uartState_reg <= usp_pkg::UART_ACTIVE;
    end
    else
    begin
      uartState_reg <= uartState_next;
    end
  end

  // Oscillator enable and settle count
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      oscRun_reg <= 1'b1;
      uartAsleep_reg <= 1'b0;
      oscCnt_reg <= '0;
    end
    else
    begin
      oscRun_reg <= (uartState_next != usp_pkg::UART_SLEEP);
      uartAsleep_reg <= (uartState_next == usp_pkg::UART_SLEEP);
      if (uartState_reg == usp_pkg::UART_WAKING && !oscSettled)
      begin
        oscCnt_reg <= oscCnt_reg + 1'b1;
      end
      else if (uartState_reg != usp_pkg::UART_WAKING)
      begin
        oscCnt_reg <= '0;
      end
    end
  end

  // Power-save isolation; holds the last bus image with strobes idle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      busIsolated_reg <= 1'b0;
      psWake_reg <= 1'b0;
      coreBus_reg <= usp_pkg::usp_bus_s'(`USP_BUS_IDLE_RST);
    end
    else
    begin
      busIsolated_reg <= isolateNow && !uartWake;
      if (isolateNow && uartWake)
      begin
        psWake_reg <= 1'b1;
      end
      else if (uartState_reg == usp_pkg::UART_ACTIVE)
      begin
        psWake_reg <= 1'b0;
      end
      if (isolateNow && !uartWake)
      begin
        coreBus_reg.chipSelectN <= 1'b1;
        coreBus_reg.readStrobeN <= 1'b1;
        coreBus_reg.writeStrobeN <= 1'b1;
      end
      else
      begin
        coreBus_reg <= busSync_reg;
      end
    end
  end

  // Wake interrupt: a new wake wins over a simultaneous status read
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wakeInt_reg <= 1'b0;
      isrNibble_reg <= 4'h0;
    end
    else
    begin
      if (wakeDone && sleepEnable && !(psWake_reg && otherIntEnabled))
      begin
        wakeInt_reg <= 1'b1;
        isrNibble_reg <= 4'h1;
      end
      else if (isrRead)
      begin
        wakeInt_reg <= 1'b0;
        isrNibble_reg <= 4'h0;
      end
    end
  end

  // Charge pump
  assign pumpEvent = rxRise || thrWrite || modemRise;
  assign oscRestart = (uartState_reg == usp_pkg::UART_SLEEP)
    && (uartState_next != usp_pkg::UART_SLEEP);
  assign pumpIdle = (uartState_reg == usp_pkg::UART_ACTIVE) && lineIdle
    && (idleCnt_reg >= PUMP_IDLE_CYCLES);

  // Idle time saturates so a long quiet line does not wrap back to zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      idleCnt_reg <= 32'h0;
    end
    else if (!lineIdle)
    begin
      idleCnt_reg <= 32'h0;
    end
    else if (idleCnt_reg != 32'hFFFFFFFF)
    begin
      idleCnt_reg <= idleCnt_reg + 32'h1;
    end
  end

  always_comb
  begin
    pumpState_next = pumpState_reg;
    unique case (pumpState_reg)
      usp_pkg::PUMP_ON:
      begin
        if (lineSync_reg.chargePumpAutosleepPin
          && (uartState_reg == usp_pkg::UART_SLEEP || pumpIdle))
        begin
          pumpState_next = usp_pkg::PUMP_OFF;
        end
      end
      usp_pkg::PUMP_OFF:
      begin
        if (!lineSync_reg.chargePumpAutosleepPin || oscRestart)
        begin
          pumpState_next = usp_pkg::PUMP_RESTART;
        end
        else if (pumpEvent && uartState_reg != usp_pkg::UART_SLEEP)
        begin
          pumpState_next = usp_pkg::PUMP_RESTART;
        end
      end
      usp_pkg::PUMP_RESTART:
      begin
        if (pumpCnt_reg == PUMP_RESTART_CYCLES)
        begin
          pumpState_next = usp_pkg::PUMP_ON;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pumpState_reg <= usp_pkg::PUMP_ON;
      pumpCnt_reg <= 13'h0;
    end
    else
    begin
      pumpState_reg <= pumpState_next;
      if (pumpState_reg == usp_pkg::PUMP_RESTART)
      begin
        pumpCnt_reg <= pumpCnt_reg + 13'h1;
      end
      else
      begin
        pumpCnt_reg <= 13'h0;
      end
    end
  end

  // Drivers only drive at full pump level; receivers are not gated here
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pumpEnable_reg <= 1'b1;
      driverEnable_reg <= 1'b1;
      fullSleep_reg <= 1'b0;
    end
    else
    begin
      pumpEnable_reg <= (pumpState_next != usp_pkg::PUMP_OFF);
      driverEnable_reg <= (pumpState_next == usp_pkg::PUMP_ON);
      fullSleep_reg <= (pumpState_next == usp_pkg::PUMP_OFF)
        && (uartState_next == usp_pkg::UART_SLEEP);
    end
  end

endmodule : usp_power_ctrl

// ==== usp_power_chk.sv ====
`timescale 1ns/100ps
module usp_power_chk (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire usp_pkg::usp_line_s linePins, // Line pins
  input wire logic intPending, // Core irq
  input wire logic [7:0] interruptEnableReg, // Enables
  input wire logic [3:0] msrChange, // Modem bits
  input wire usp_pkg::usp_bus_s coreBus_reg, // Core bus
  input wire logic oscRun_reg, // Oscillator
  input wire logic uartAsleep_reg, // Asleep
  input wire logic busIsolated_reg, // Isolated
  input wire logic wakeInt_reg, // Wake irq
  input wire logic [3:0] isrNibble_reg, // Nibble
  input wire logic pumpEnable_reg, // Pump
  input wire logic driverEnable_reg, // Drivers
  input wire logic fullSleep_reg // Full sleep
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_osc;
    oscRun_reg != uartAsleep_reg;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator wrong");
  property p_nib;
    isrNibble_reg == (wakeInt_reg ? 4'h1 : 4'h0);
  endproperty
  a_nib: assert property (p_nib) else $error("nibble wrong");
  property p_sleep;
    $rose(uartAsleep_reg) |-> !$past(intPending) && !$past(wakeInt_reg)
      && $past(interruptEnableReg[4]) && $past(msrChange) == 4'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bad sleep entry");
  property p_ier;
    !interruptEnableReg[4] |=> !uartAsleep_reg;
  endproperty
  a_ier: assert property (p_ier) else $error("asleep while disabled");
  property p_acp;
    !linePins.chargePumpAutosleepPin [*4] |-> pumpEnable_reg;
  endproperty
  a_acp: assert property (p_acp) else $error("pump off with pin low");
  property p_drv;
    !pumpEnable_reg |-> !driverEnable_reg;
  endproperty
  a_drv: assert property (p_drv) else $error("drivers on, pump off");
  property p_restart;
    $rose(pumpEnable_reg) |-> !driverEnable_reg [*8];
  endproperty
  a_restart: assert property (p_restart) else $error("drivers early");
  property p_full;
    fullSleep_reg == (uartAsleep_reg && !pumpEnable_reg)
      && (!fullSleep_reg || $past(linePins.chargePumpAutosleepPin, 3));
  endproperty
  a_full: assert property (p_full) else $error("full sleep wrong");
  property p_iso;
    busIsolated_reg |-> uartAsleep_reg && coreBus_reg.chipSelectN
      && coreBus_reg.readStrobeN && coreBus_reg.writeStrobeN;
  endproperty
  a_iso: assert property (p_iso) else $error("bus not isolated");
  property p_wake;
    $rose(wakeInt_reg) |-> $past(oscRun_reg, 120) && !busIsolated_reg;
  endproperty
  a_wake: assert property (p_wake) else $error("wake irq early");
endmodule : usp_power_chk

// ==== usp_host.sv ====
`timescale 1ns/100ps
module usp_host (
  input wire logic clk, // Clock
  input wire logic wake, // Wake irq seen
  input wire logic noisy, // Toggle bus lines
  input wire logic [7:0] lat, // Service delay
  output usp_pkg::usp_bus_s bus, // Bus pins
  output logic isrRead // Status read pulse
);
  logic [7:0] cnt = 8'h00;
  int seed = 32'h1838;
  initial
  begin
    bus = 14'h3FFF;
    isrRead = 1'b0;
  end
  // A real host keeps wiggling the bus while the part sleeps
  always @(negedge clk)
  begin
    bus <= noisy ? 14'($random(seed)) : 14'h3FFF;
    isrRead <= 1'b0;
    if (wake && !isrRead)
    begin
      cnt <= cnt + 8'h01;
      if (cnt >= lat)
      begin
        isrRead <= 1'b1;
        cnt <= 8'h00;
      end
    end
  end
endmodule : usp_host

// ==== usp_power_ctrl_tb.sv ====
`timescale 1ns/100ps
module usp_power_ctrl_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  usp_pkg::usp_line_s line = '0;
  usp_pkg::usp_bus_s bus;
  usp_pkg::usp_bus_s cb;
  logic ip = 1'b0;
  logic [15:0] div = 16'h0001;
  logic [7:0] interrupt_enable_reg = 8'h00;
  logic [3:0] modem_status_reg = 4'h0;
  logic tx = 1'b0;
  logic transmit_holding_reg = 1'b0;
  logic noisy = 1'b0;
  logic [7:0] lat = 8'h02;
  logic rd, osc, slp, iso, wi, pe, de, fs;
  logic [3:0] nib;
  logic [5:0] ov;
  int seed = 32'h1838;
  int badCount = 0;
  int checks = 0;
  assign ov = {iso, fs, de, pe, wi, slp};
  initial forever #4 clk = ~clk;
  usp_power_ctrl #(.PUMP_IDLE_CYCLES(32'h32), .PUMP_RESTART_CYCLES(13'hA)) uut (
    .clk(clk), .rst_b(rst_b), .linePins(line), .busPins(bus), .intPending(ip),
    .baudDivisor(div), .interruptEnableReg(interrupt_enable_reg), .msrChange(modem_status_reg), .txActive(tx),
    .thrWrite(transmit_holding_reg), .isrRead(rd), .coreBus_reg(cb), .oscRun_reg(osc),
    .uartAsleep_reg(slp), .busIsolated_reg(iso), .wakeInt_reg(wi),
    .isrNibble_reg(nib), .pumpEnable_reg(pe), .driverEnable_reg(de), .fullSleep_reg(fs));
  usp_host host (.clk(clk), .wake(wi), .noisy(noisy), .lat(lat), .bus(bus), .isrRead(rd));
  task test_done();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task chk(input string n, input logic [3:0] s, input logic [3:0] e);
    checks++;
    if (s !== e)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Bounded wait on one output; a miss ends the run
  task wt(input int k, input logic v, input int n);
    int i;
    for (i = 0; i < n && ov[k] !== v; i++)
      @(negedge clk);
    chk($sformatf("out%0d", k), {3'h0, ov[k]}, {3'h0, v});
    if (ov[k] !== v)
      test_done();
  endtask : wt
  function logic sleepOk(input logic [15:0] d, input logic [7:0] e, input logic [3:0] m,
    input logic r, input logic p);
    return d != 16'h0000 && e[4] && m == 4'h0 && !r && !p;
  endfunction : sleepOk
  task goSleep();
    {ip, modem_status_reg, line.rxd, div, interrupt_enable_reg} = {1'b0, 4'h0, 1'b0, 16'h0100, 8'h10};
    wt(0, 1'b1, 10);
  endtask : goSleep
  initial
  begin
    cyc(12);
    rst_b = 1'b1;
    cyc(3);
    chk("osc", {3'h0, osc}, 4'h1);
    chk("pump", {3'h0, pe}, 4'h1);
    repeat (16)
    begin
      interrupt_enable_reg = 8'h00;
      // A wake by clearing sleep-enable runs the whole oscillator settle first
      cyc(130);
      div = ($random(seed) & 1) ? 16'($random(seed) & 3) : 16'hABCD;
      interrupt_enable_reg = 8'($random(seed));
      modem_status_reg = (($random(seed) & 3) == 0) ? 4'($random(seed)) : 4'h0;
      line.rxd = ($random(seed) & 3) == 0;
      ip = ($random(seed) & 3) == 0;
      cyc(8);
      chk("sleep", {3'h0, slp}, {3'h0, sleepOk(div, interrupt_enable_reg, modem_status_reg, line.rxd, ip)});
      chk("osc", {3'h0, osc}, {3'h0, !sleepOk(div, interrupt_enable_reg, modem_status_reg, line.rxd, ip)});
    end
    $display("sleep terms done");
    for (int k = 0; k < 3; k++)
    begin
      lat = 8'($random(seed) & 15);
      goSleep();
      line.rxd = k == 0;
      transmit_holding_reg = k == 1;
      modem_status_reg = (k == 2) ? 4'h4 : 4'h0;
      cyc(1);
      transmit_holding_reg = 1'b0;
      wt(0, 1'b0, 4);
      wt(1, 1'b1, 140);
      chk("nibble", nib, 4'h1);
      line.rxd = 1'b0;
      wt(1, 1'b0, 40);
      cyc(4);
      chk("resleep", {3'h0, slp}, {3'h0, k != 2});
      modem_status_reg = 4'h0;
      wt(0, 1'b1, 10);
    end
    interrupt_enable_reg = 8'h00;
    wt(0, 1'b0, 4);
    cyc(140);
    chk("noint", {3'h0, wi}, 4'h0);
    $display("wake done");
    line.chargePumpAutosleepPin = 1'b1;
    tx = 1'b1;
    cyc(80);
    chk("pumpbusy", {3'h0, pe}, 4'h1);
    tx = 1'b0;
    wt(2, 1'b0, 70);
    chk("drv", {3'h0, de}, 4'h0);
    line.rxd = 1'b1;
    wt(2, 1'b1, 5);
    wt(3, 1'b1, 20);
    goSleep();
    wt(4, 1'b1, 10);
    line.chargePumpAutosleepPin = 1'b0;
    wt(2, 1'b1, 6);
    wt(3, 1'b1, 20);
    $display("pump done");
    line.busIsolatePin = 1'b1;
    noisy = 1'b1;
    wt(5, 1'b1, 10);
    chk("strobes", {1'b0, cb.chipSelectN, cb.readStrobeN, cb.writeStrobeN}, 4'h7);
    transmit_holding_reg = 1'b1;
    cyc(1);
    transmit_holding_reg = 1'b0;
    cyc(6);
    chk("ignored", {3'h0, slp}, 4'h1);
    modem_status_reg = 4'h8;
    wt(1, 1'b1, 140);
    wt(1, 1'b0, 40);
    modem_status_reg = 4'h0;
    wt(5, 1'b1, 12);
    interrupt_enable_reg = 8'h11;
    modem_status_reg = 4'h2;
    wt(0, 1'b0, 6);
    cyc(140);
    chk("hidden", {3'h0, wi}, 4'h0);
    modem_status_reg = 4'h0;
    wt(5, 1'b1, 12);
    $display("power save done");
    test_done();
  end
endmodule : usp_power_ctrl_tb
bind usp_power_ctrl usp_power_chk chk_i (
  .clk(clk), .rst_b(rst_b), .linePins(linePins), .intPending(intPending),
  .interruptEnableReg(interruptEnableReg), .msrChange(msrChange), .coreBus_reg(coreBus_reg),
  .oscRun_reg(oscRun_reg), .uartAsleep_reg(uartAsleep_reg), .busIsolated_reg(busIsolated_reg),
  .wakeInt_reg(wakeInt_reg), .isrNibble_reg(isrNibble_reg), .pumpEnable_reg(pumpEnable_reg),
  .driverEnable_reg(driverEnable_reg), .fullSleep_reg(fullSleep_reg));
